// file: inc/bmc_pkg.sv
// Summary of operation
// - shared bus error enable, bit 20, resets one
// - debug unit error enable, bit 19, resets one
// - dma engine error enable, bit 18, resets one
// - cpu data error enable, bit 17, debug-suppressed
// - cpu fetch error enable, bit 16, debug-suppressed
// - bit 6 adds one data ram wait
// - bits 2:0 select arbitration mode, reset 001
// - unimplemented bits always read back zero
package bmc_pkg;
	// ------------------------------------------------------------
	// initiators, one error enable each
	// ------------------------------------------------------------
	localparam int         NINIT      = 5;
	localparam int         IX_CPU_INS = 0;     // cpu instruction port
	localparam int         IX_CPU_DAT = 1;     // cpu data port
	localparam int         IX_DMA     = 2;     // dma engine
	localparam int         IX_DEBUG   = 3;     // in-circuit debug unit
	localparam int         IX_SHARED  = 4;     // shared peripheral bus
	localparam logic [4:0] DBG_SUPP   = 5'h03; // cpu ports muted in debug
	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam int         AW         = 4;
	localparam logic [3:0] OFS_CFG    = 4'h0;
	localparam logic [3:0] OFS_STS    = 4'h4;
	localparam logic [3:0] OFS_MSK    = 4'h8;
	// ------------------------------------------------------------
	// configuration register layout
	// ------------------------------------------------------------
	localparam int          ERR_LSB   = 16;
	localparam int          WS_BIT    = 6;
	localparam int          ARB_LSB   = 0;
	localparam int          ARB_W     = 3;
	localparam logic [31:0] CFG_RST   = 32'h001F_0041;
	localparam logic [31:0] CFG_WMASK = 32'h001F_0047;
	localparam logic [4:0]  IRQ_WMASK = 5'h1F;
	// ------------------------------------------------------------
	// avalon response codes
	// ------------------------------------------------------------
	localparam logic [1:0]  RSP_OKAY  = 2'h0;
	localparam logic [1:0]  RSP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO32    = 32'h0000_0000;
	localparam logic [4:0]  ZERO5     = 5'h00;
endpackage : bmc_pkg

// file: inc/bmc_link_if.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// carrier between the register front end and its helpers
// ------------------------------------------------------------
interface bmc_link_if;
	logic [4:0] err_en;   // per-initiator error enables
	logic [4:0] unmapped; // unmapped access pulses
	logic       dbg_mode; // processor in debug mode
	logic [4:0] err_hit;  // error response pulses
	logic       ws_en;    // one address-setup wait
	logic       dram_req; // cpu data ram request
	logic       dram_ack; // cpu data ram completion
	modport ctl (output err_en, unmapped, dbg_mode, ws_en, dram_req,
		input err_hit, dram_ack);
	modport err (input err_en, unmapped, dbg_mode, output err_hit);
	modport ws (input ws_en, dram_req, output dram_ack);
endinterface : bmc_link_if

// file: src/bmc_err_gate.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// unmapped access error gating, one lane per initiator
// ------------------------------------------------------------
module bmc_err_gate import bmc_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	bmc_link_if.err  lnk
);
	typedef struct packed { logic [4:0] hit; } bmc_gate_t;
	bmc_gate_t  s_q, s_d;  // all state of the gate
	logic [4:0] pass;      // lane verdicts
	// per-lane verdict; cpu lanes go quiet in debug mode
	for (genvar i = 0; i < NINIT; i++) begin : g_lane
		assign pass[i] = lnk.unmapped[i] & lnk.err_en[i] & ~(DBG_SUPP[i] & lnk.dbg_mode);
	end
	// next state
	always_comb begin
		s_d.hit = pass;
	end
	// registered so the response never glitches
	always_ff @(posedge clk) begin
		if (!nrst) s_q <= '{hit: ZERO5};
		else s_q <= s_d;
	end
	assign lnk.err_hit = s_q.hit;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_shared_err_on: assert property (lnk.unmapped[IX_SHARED] && lnk.err_en[IX_SHARED] |=> lnk.err_hit[IX_SHARED]) else $error("shared bus error lost");
	a_debug_err_on: assert property (lnk.unmapped[IX_DEBUG] && lnk.err_en[IX_DEBUG] |=> lnk.err_hit[IX_DEBUG]) else $error("debug unit error lost");
	a_dma_err_on: assert property (lnk.unmapped[IX_DMA] && lnk.err_en[IX_DMA] |=> lnk.err_hit[IX_DMA]) else $error("dma error lost");
	a_cpu_data_dbg: assert property (lnk.unmapped[IX_CPU_DAT] && lnk.err_en[IX_CPU_DAT] |=> lnk.err_hit[IX_CPU_DAT] == !$past(lnk.dbg_mode)) else $error("cpu data error wrong");
	a_cpu_fetch_dbg: assert property (lnk.unmapped[IX_CPU_INS] && lnk.err_en[IX_CPU_INS] |=> lnk.err_hit[IX_CPU_INS] == !$past(lnk.dbg_mode)) else $error("cpu fetch error wrong");
	a_no_err_off: assert property ((lnk.err_hit & ~$past(lnk.err_en & lnk.unmapped)) == ZERO5) else $error("error without enable");
endmodule : bmc_err_gate

// file: src/bmc_ws_gen.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// data ram wait state generator for cpu accesses
// ------------------------------------------------------------
module bmc_ws_gen import bmc_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	bmc_link_if.ws   lnk
);
	typedef struct packed {
		logic pend; // setup cycle spent
		logic ack;  // completion pulse
	} bmc_ws_t;
	bmc_ws_t s_q, s_d;
	// request is held until ack; the ack cycle itself opens nothing new
	always_comb begin
		s_d.pend = lnk.dram_req & ~s_q.ack & ~s_q.pend & lnk.ws_en;
		s_d.ack  = lnk.dram_req & ~s_q.ack & (~lnk.ws_en | s_q.pend);
	end
	// state register
	always_ff @(posedge clk) begin
		if (!nrst) s_q <= '{pend: 1'b0, ack: 1'b0};
		else s_q <= s_d;
	end
	assign lnk.dram_ack = s_q.ack;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ws_zero: assert property (lnk.dram_req && !s_q.ack && !s_q.pend && !lnk.ws_en |=> lnk.dram_ack) else $error("zero wait access late");
	a_ws_one: assert property ((lnk.dram_req && !s_q.ack && !s_q.pend && lnk.ws_en ##1 lnk.dram_req) |-> !lnk.dram_ack ##1 lnk.dram_ack) else $error("one wait access wrong");
endmodule : bmc_ws_gen

// file: src/bmc_top.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
// ------------------------------------------------------------
// bus matrix configuration block, avalon-mm slave
// ------------------------------------------------------------
module bmc_top import bmc_pkg::*; (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [1:0]  avs_response,
	input  wire logic [4:0]  unmapped_access,
	input  wire logic        debug_mode,
	input  wire logic        dram_req,
	output logic             dram_ack,
	output logic      [4:0]  bus_err,
	output logic      [2:0]  arbitration_mode_sel,
	output logic             irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cfg;   // configuration register
		logic [4:0]  sts;   // sticky error events
		logic [4:0]  msk;   // interrupt mask
		logic [31:0] rdata; // read data to bus
		logic [1:0]  resp;  // avalon response
		logic        wreq;  // waitrequest
		logic        irq;   // interrupt line
	} bmc_top_t;

	bmc_top_t    s_q;       // registered state
	bmc_top_t    s_d;       // next state
	logic [31:0] be_mask;   // byte enables widened to bits
	logic        req;       // read or write pending
	logic        taken;     // request completes this edge
	logic        wr_cfg;    // write to configuration
	logic        wr_sts;    // write-one-to-clear to status
	logic        wr_msk;    // write to mask
	logic        mapped;    // address decodes
	logic [31:0] wr_bits;   // write data under byte enables

	bmc_link_if lnk ();     // helper carrier

	// ------------------------------------------------------------
	// byte lanes
	// ------------------------------------------------------------
	// each byte enable covers eight data bits
	for (genvar b = 0; b < 4; b++) begin : g_be
		assign be_mask[8*b +: 8] = {8{avs_byteenable[b]}};
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// the first request cycle sees waitrequest high; it drops the
	// next cycle and that edge completes the transfer
	assign req     = avs_read | avs_write;
	assign taken   = req & ~s_q.wreq;
	assign mapped  = (avs_address == OFS_CFG) |
		(avs_address == OFS_STS) |
		(avs_address == OFS_MSK);
	assign wr_bits = avs_writedata & be_mask;
	assign wr_cfg  = taken & avs_write & (avs_address == OFS_CFG);
	assign wr_sts  = taken & avs_write & (avs_address == OFS_STS);
	assign wr_msk  = taken & avs_write & (avs_address == OFS_MSK);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// error enables go out straight from the stored bits
	assign lnk.err_en   = s_q.cfg[ERR_LSB +: NINIT];
	assign lnk.unmapped = unmapped_access;
	assign lnk.dbg_mode = debug_mode;
	assign lnk.ws_en    = s_q.cfg[WS_BIT];
	assign lnk.dram_req = dram_req;

	// error lanes, one per initiator
	bmc_err_gate u_err (
		.clk  (clk),
		.nrst (nrst),
		.lnk  (lnk)
	);

	// cpu data ram wait states
	bmc_ws_gen u_ws (
		.clk  (clk),
		.nrst (nrst),
		.lnk  (lnk)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// handshake: drop wait for exactly one cycle per request
		if (req && s_q.wreq) begin
			s_d.wreq = 1'b0;
		end else begin
			s_d.wreq = 1'b1;
		end

		// read data and response are prepared while still waiting,
		// so they stand at the completing edge
		if (req && s_q.wreq) begin
			case (avs_address)
				OFS_CFG: begin
					// unimplemented bits are never stored, read zero
					s_d.rdata = s_q.cfg & CFG_WMASK;
					s_d.resp  = RSP_OKAY;
				end
				OFS_STS: begin
					s_d.rdata = {27'h000_0000, s_q.sts};
					s_d.resp  = RSP_OKAY;
				end
				OFS_MSK: begin
					s_d.rdata = {27'h000_0000, s_q.msk};
					s_d.resp  = RSP_OKAY;
				end
				default: begin
					// unmapped offset: zero data, slave error
					s_d.rdata = ZERO32;
					s_d.resp  = RSP_SLVERR;
				end
			endcase
		end

		// configuration write, only implemented bits land
		if (wr_cfg) begin
			s_d.cfg = (s_q.cfg & ~(be_mask & CFG_WMASK)) |
				(wr_bits & CFG_WMASK);
		end
		// reserved arbitration codes are stored as written; the
		// matrix behaviour for them is left to software to avoid

		// mask write
		if (wr_msk) begin
			s_d.msk = (s_q.msk & ~(be_mask[4:0] & IRQ_WMASK)) |
				(wr_bits[4:0] & IRQ_WMASK);
		end

		// status: write one clears, a new event in the same cycle
		// wins over the clear so none is lost
		s_d.sts = s_q.sts;
		if (wr_sts) begin
			s_d.sts = s_q.sts & ~(wr_bits[4:0] & IRQ_WMASK);
		end
		s_d.sts = s_d.sts | lnk.err_hit;

		// level interrupt from the next state, so it follows the
		// status and mask with no extra cycle
		s_d.irq = |(s_d.sts & s_d.msk);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// synchronous reset; enables and wait bit come up set, mode 1
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '{
				cfg:   CFG_RST,
				sts:   ZERO5,
				msk:   ZERO5,
				rdata: ZERO32,
				resp:  RSP_OKAY,
				wreq:  1'b1,
				irq:   1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, each straight from a flip-flop
	// ------------------------------------------------------------
	assign avs_readdata         = s_q.rdata;
	assign avs_waitrequest      = s_q.wreq;
	assign avs_response         = s_q.resp;
	assign dram_ack             = lnk.dram_ack;
	assign bus_err              = lnk.err_hit;
	assign arbitration_mode_sel = s_q.cfg[ARB_LSB +: ARB_W];
	assign irq                  = s_q.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_arb_field_write: assert property (wr_cfg && avs_byteenable[0] |=> arbitration_mode_sel == $past(avs_writedata[2:0])) else $error("arbitration field not written");
	a_unimpl_zero: assert property (taken && avs_read && avs_address == OFS_CFG |-> (avs_readdata & ~CFG_WMASK) == ZERO32) else $error("unimplemented bits read nonzero");
	a_ws_bit_tracks: assert property (wr_cfg && avs_byteenable[0] |=> lnk.ws_en == $past(avs_writedata[6])) else $error("wait state bit not written");
	a_err_en_write: assert property (wr_cfg && avs_byteenable[2] |=> lnk.err_en == $past(avs_writedata[20:16])) else $error("error enables not written");
	a_sticky_event: assert property (|lnk.err_hit |=> (s_q.sts & $past(lnk.err_hit)) == $past(lnk.err_hit)) else $error("error event lost");
endmodule : bmc_top

// file: sim/bmc_init_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// bus initiators: cpu ports, dma, debug unit, shared bus
// ------------------------------------------------------------
module bmc_init_model (
	input  wire logic       clk,
	input  wire logic       dram_ack,
	output logic      [4:0] unmapped_access,
	output logic            debug_mode,
	output logic            dram_req
);
	// idle at time zero, no access in flight
	initial begin
		unmapped_access = 5'h00;
		debug_mode      = 1'b0;
		dram_req        = 1'b0;
	end
	// one-cycle unmapped access strobe per lane, returns once the answer has settled
	task automatic strobe(input logic [4:0] m);
		@(posedge clk) unmapped_access <= m;
		@(posedge clk) unmapped_access <= 5'h00;
		#1;
	endtask : strobe
	// processor enters or leaves debug mode
	task automatic set_dbg(input logic v);
		@(posedge clk) debug_mode <= v;
	endtask : set_dbg
	// data ram access held until ack; the count is bounded so a lost ack cannot hang us
	task automatic ram_access(output int n);
		@(posedge clk) dram_req <= 1'b1;
		n = 0;
		while (n < 8) begin
			@(posedge clk);
			#1;
			n++;
			if (dram_ack === 1'b1) begin
				break;
			end
		end
		@(posedge clk) dram_req <= 1'b0;
	endtask : ram_access
endmodule : bmc_init_model

// file: sim/bus_matrix_config_tb.sv
`timescale 1ns/100ps
module bus_matrix_config_tb;
	import bmc_pkg::*;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic        clk, nrst, avs_read, avs_write, avs_waitrequest, dram_req, dram_ack, debug_mode, irq;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0]  avs_response;
	logic [4:0]  unmapped_access, bus_err;
	logic [2:0]  arbitration_mode_sel;
	int          err_count, total_checks;
	bmc_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.unmapped_access(unmapped_access), .debug_mode(debug_mode), .dram_req(dram_req),
		.dram_ack(dram_ack), .bus_err(bus_err), .arbitration_mode_sel(arbitration_mode_sel), .irq(irq));
	bmc_init_model ini (.clk(clk), .dram_ack(dram_ack), .unmapped_access(unmapped_access),
		.debug_mode(debug_mode), .dram_req(dram_req));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(input logic is_wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
		output logic [31:0] rd, output logic [1:0] rsp);
		int n;
		@(posedge clk);
		avs_address    <= a;
		avs_writedata  <= wd;
		avs_byteenable <= be;
		avs_write      <= is_wr;
		avs_read       <= ~is_wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			close_out();
		end
	endtask : xfer
	// write with chosen byte lanes
	task automatic wr_be(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] rd;
		logic [1:0]  rsp;
		xfer(1'b1, a, d, be, rd, rsp);
	endtask : wr_be
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wr_be(a, d, 4'hF);
	endtask : wr
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rexp);
		logic [31:0] rd;
		logic [1:0]  rsp;
		xfer(1'b0, a, 32'h0000_0000, 4'hF, rd, rsp);
		check(rd, exp);
		check(32'(rsp), 32'(rexp));
	endtask : rd_chk
	// irq is looked at one edge after the write that changed its cause
	task automatic irq_chk(input logic exp);
		@(posedge clk);
		#1;
		check(32'(irq), 32'(exp));
	endtask : irq_chk
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd_chk(OFS_CFG, 32'h001F_0041, 2'h0);
		check(32'(arbitration_mode_sel), 32'h0000_0001);
		ini.strobe(5'h1F);
		check(32'(bus_err), 32'h0000_001F);
		$display("test reset done");
	endtask : t_reset
	task automatic t_config();
		// only legal arbitration codes are ever written
		wr(OFS_CFG, 32'hFFFF_FFFA);
		rd_chk(OFS_CFG, 32'h001F_0042, 2'h0);
		for (int c = 0; c < 3; c++) begin
			wr(OFS_CFG, 32'(c));
			// the write lands on the completing edge; look once it has settled
			#1;
			check(32'(arbitration_mode_sel), 32'(c));
			rd_chk(OFS_CFG, 32'(c), 2'h0);
		end
		// single byte lanes: only the enabled byte may change
		wr_be(OFS_CFG, 32'hFFFF_FFFF, 4'h4);
		rd_chk(OFS_CFG, 32'h001F_0002, 2'h0);
		wr_be(OFS_CFG, 32'h0000_0041, 4'h1);
		rd_chk(OFS_CFG, 32'h001F_0041, 2'h0);
		rd_chk(4'hC, 32'h0000_0000, 2'h2);
		$display("test config done");
	endtask : t_config
	task automatic t_lanes();
		// one lane disabled at a time, all lanes strobed together
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CFG, 32'h001F_0041 & ~(32'h0000_0001 << (16 + i)));
			ini.strobe(5'h1F);
			check(32'(bus_err), 32'h0000_001F & ~(32'h0000_0001 << i));
		end
		wr(OFS_CFG, 32'h001F_0041);
		ini.set_dbg(1'b1);
		ini.strobe(5'h1F);
		check(32'(bus_err), 32'h0000_001C);
		ini.set_dbg(1'b0);
		ini.strobe(5'h03);
		check(32'(bus_err), 32'h0000_0003);
		$display("test lanes done");
	endtask : t_lanes
	task automatic t_irq();
		wr(OFS_STS, 32'h0000_001F);
		wr(OFS_MSK, 32'h0000_0004);
		// status and irq rise one edge after the bus_err pulse
		ini.strobe(5'h08);
		irq_chk(1'b0);
		ini.strobe(5'h04);
		irq_chk(1'b1);
		rd_chk(OFS_STS, 32'h0000_000C, 2'h0);
		wr(OFS_MSK, 32'h0000_0000);
		irq_chk(1'b0);
		wr(OFS_MSK, 32'h0000_0004);
		irq_chk(1'b1);
		wr(OFS_STS, 32'h0000_0004);
		irq_chk(1'b0);
		rd_chk(OFS_STS, 32'h0000_0008, 2'h0);
		$display("test irq done");
	endtask : t_irq
	task automatic t_wait();
		int n;
		wr(OFS_CFG, 32'h001F_0041);
		ini.ram_access(n);
		check(32'(n), 32'h0000_0002);
		wr(OFS_CFG, 32'h001F_0001);
		ini.ram_access(n);
		check(32'(n), 32'h0000_0001);
		$display("test wait done");
	endtask : t_wait
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		err_count      = 0;
		total_checks   = 0;
		nrst           = 1'b0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_address    = 4'h0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_config();
		t_lanes();
		t_irq();
		t_wait();
		close_out();
	end
endmodule : bus_matrix_config_tb
